//--- hw/fault_lock_pkg.sv
// Constants and carrier types for the line-fault and lock status block.
// Assumes a single 200 MHz clock domain (mclk).
package fault_lock_pkg;

    localparam int unsigned CLK_PERIOD_PS      = 5000;
    // Reverse channel blackout after link start or stop, in ns
    localparam int unsigned REV_BLACKOUT_NS    = 350000;
    localparam int unsigned REV_BLACKOUT_CYCLES =
        (REV_BLACKOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Highest control bit rate, in kbit/s
    localparam int unsigned CTRL_MAX_KBPS      = 1000;
    localparam int unsigned CTRL_BIT_CYCLES    =
        (1000000000 / CLK_PERIOD_PS) / CTRL_MAX_KBPS;

    localparam logic [7:0] CABLE_FAULT_STATUS_ADDR = 8'h08;
    localparam logic [7:0] CABLE_FAULT_STATUS_RST  = 8'h0A;
    localparam int unsigned NEG_FIELD_LSB = 2;
    localparam int unsigned POS_FIELD_LSB = 0;

    typedef enum logic [1:0] {
        WIRE_SHORT_BATTERY = 2'h0,
        WIRE_SHORT_GROUND  = 2'h1,
        WIRE_NORMAL        = 2'h2,
        WIRE_OPEN          = 2'h3
    } wire_fault_type;

    typedef struct packed {
        wire_fault_type neg_wire_fault_type;
        wire_fault_type pos_wire_fault_type;
    } fault_pair_type;

endpackage

//--- hw/pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous inputs.
// Assumes the destination clock is mclk; first stage read by second only.
`timescale 1ns/1ps
module pin_sync
    import fault_lock_pkg::*;
#(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1   = stage1;
        next_sync_out = sync_out;
        if (!resetn) begin
            next_stage1   = RESET_VALUE;
            next_sync_out = RESET_VALUE;
        end else if (clk_en) begin
            next_stage1   = async_in;
            next_sync_out = stage1;
        end
    end

    always_ff @(posedge mclk) begin
        stage1   <= next_stage1;
        sync_out <= next_sync_out;
    end
endmodule // pin_sync

//--- hw/line_fault_and_lock_report.sv
// Lock loopback relay and cable line-fault reporting of the serializer.
// Assumes detector and reverse-channel inputs are asynchronous to mclk.
`timescale 1ns/1ps

// How it works
// - Interrupt output follows each valid remote lock message; lock is held while the reverse channel blackout runs.
// - Lock messages are tracked even while the forward link is idle.
// - Fault flag pin low while any wire fault, high when normal.
// - Fault type sits in bits 3:0 of status register cable_fault_status.
// - Negative wire field bits 3:2: battery, ground, normal, open.
// - Positive wire field bits 1:0: battery, ground, normal, open.
// - Control interface works at bit rates up to 1 Mbps.
// - Reverse channel unavailable for 350 us after link start or stop.
module line_fault_and_lock_report
    import fault_lock_pkg::*;
#(
    parameter int unsigned BLACKOUT_CYCLES = REV_BLACKOUT_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        rev_lock_msg,
    input  wire logic        rev_lock_valid,
    input  wire logic        serial_link_en,
    input  wire logic [1:0]  neg_detect,
    input  wire logic [1:0]  pos_detect,
    input  wire logic [7:0]  reg_addr,
    output logic      [7:0]  reg_rdata,
    output logic             int_out,
    output logic             line_fault_flag_n,
    output logic             rev_chan_ready
);
    localparam int unsigned CW = $clog2(BLACKOUT_CYCLES + 1);
    localparam logic [CW-1:0] BLACKOUT_LOAD = CW'(BLACKOUT_CYCLES);

    logic [5:0]     sync_q;
    fault_pair_type faults;
    logic           lock_s;
    logic           valid_s;
    logic           link_en_s;

    pin_sync #(
        .WIDTH       (6),
        .RESET_VALUE ({2'h2, 2'h2, 2'h0})
    ) u_sync (
        .mclk     (mclk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in ({neg_detect, pos_detect, rev_lock_msg, rev_lock_valid}),
        .sync_out (sync_q)
    );

    // Link enable is a same-domain control, not synchronised
    assign link_en_s = serial_link_en;
    assign faults    = fault_pair_type'(sync_q[5:2]);
    assign lock_s    = sync_q[1];
    assign valid_s   = sync_q[0];

    function automatic logic wire_faulty(input wire_fault_type t);
        return t != WIRE_NORMAL;
    endfunction

    logic            link_en_q;
    logic [CW-1:0]   blackout;
    logic            lock_q;
    logic            next_link_en_q;
    logic [CW-1:0]   next_blackout;
    logic            next_lock_q;
    logic            next_int_out;
    logic            next_flag_n;
    logic [7:0]      next_rdata;
    logic            next_ready;
    logic [7:0]      status;

    always_comb begin
        status = {4'h0, faults.neg_wire_fault_type,
                  faults.pos_wire_fault_type};
        next_link_en_q = link_en_q;
        next_blackout  = blackout;
        next_lock_q    = lock_q;
        next_int_out   = int_out;
        next_flag_n    = line_fault_flag_n;
        next_rdata     = reg_rdata;
        next_ready     = rev_chan_ready;
        if (!resetn) begin
            next_link_en_q = 1'b0;
            next_blackout  = '0;
            next_lock_q    = 1'b0;
            next_int_out   = 1'b0;
            next_flag_n    = 1'b1;
            next_rdata     = CABLE_FAULT_STATUS_RST;
            next_ready     = 1'b1;
        end else if (clk_en) begin
            next_link_en_q = link_en_s;
            // Any start or stop of the link restarts the blackout
            if (link_en_s != link_en_q) begin
                next_blackout = BLACKOUT_LOAD;
            end else if (blackout != '0) begin
                next_blackout = blackout - CW'(1);
            end
            next_ready = (next_blackout == '0);
            // Forward link state not consulted: reverse path runs alone
            if (valid_s && (blackout == '0)) begin
                next_lock_q = lock_s;
            end
            next_int_out = next_lock_q;
            // Flag and fields come from the same synced sample
            next_flag_n = !(wire_faulty(faults.neg_wire_fault_type)
                         || wire_faulty(faults.pos_wire_fault_type));
            // Read-only: no write path exists for the fields
            // One-cycle answer, far inside a 1 Mbps bit time
            next_rdata = (reg_addr == CABLE_FAULT_STATUS_ADDR)
                         ? status : 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        link_en_q         <= next_link_en_q;
        blackout          <= next_blackout;
        lock_q            <= next_lock_q;
        int_out           <= next_int_out;
        line_fault_flag_n <= next_flag_n;
        reg_rdata         <= next_rdata;
        rev_chan_ready    <= next_ready;
    end

    property p_lock_follow;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && valid_s && blackout == '0 && !$changed(link_en_s)
         && link_en_s == link_en_q)
        |=> (int_out == $past(lock_s));
    endproperty
    a_lock_follow: assert property (p_lock_follow)
        else $error("interrupt did not follow lock");

    property p_flag_low;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && faults.pos_wire_fault_type != WIRE_NORMAL)
        |=> !line_fault_flag_n;
    endproperty
    a_flag_low: assert property (p_flag_low)
        else $error("fault flag not low on positive fault");

    property p_flag_low_neg;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && faults.neg_wire_fault_type != WIRE_NORMAL)
        |=> !line_fault_flag_n;
    endproperty
    a_flag_low_neg: assert property (p_flag_low_neg)
        else $error("fault flag not low on negative fault");

    property p_flag_high;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && faults == {WIRE_NORMAL, WIRE_NORMAL})
        |=> line_fault_flag_n;
    endproperty
    a_flag_high: assert property (p_flag_high)
        else $error("fault flag not high on normal line");

    property p_status_read;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && reg_addr == CABLE_FAULT_STATUS_ADDR)
        |=> (reg_rdata[3:0] == $past(status[3:0]) && reg_rdata[7:4] == 4'h0);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status register mismatch");

    // Pin is three edges back only if both sync stages really ran
    property p_neg_field;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && $past(clk_en) && $past(resetn) && $past(clk_en, 2)
         && $past(resetn, 2) && reg_addr == CABLE_FAULT_STATUS_ADDR)
        |=> (reg_rdata[3:2] == $past(neg_detect, 3));
    endproperty
    a_neg_field: assert property (p_neg_field)
        else $error("negative field wrong");

    property p_pos_field;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && $past(clk_en) && $past(resetn) && $past(clk_en, 2)
         && $past(resetn, 2) && reg_addr == CABLE_FAULT_STATUS_ADDR)
        |=> (reg_rdata[1:0] == $past(pos_detect, 3));
    endproperty
    a_pos_field: assert property (p_pos_field)
        else $error("positive field wrong");

    property p_blackout;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && link_en_s != link_en_q) |=> (!rev_chan_ready)[*2];
    endproperty
    a_blackout: assert property (p_blackout)
        else $error("reverse channel ready during blackout");

    property p_hold_lock;
        @(posedge mclk) disable iff (!resetn)
        (blackout != '0) |=> $stable(lock_q);
    endproperty
    a_hold_lock: assert property (p_hold_lock)
        else $error("lock updated during blackout");

    property p_consistent;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && $past(clk_en) && reg_addr == CABLE_FAULT_STATUS_ADDR)
        |=> (line_fault_flag_n == (reg_rdata[3:0] == 4'hA));
    endproperty
    a_consistent: assert property (p_consistent)
        else $error("flag and fields disagree");

endmodule // line_fault_and_lock_report

//--- verification/remote_deser_model.sv
// Behavioural remote deserializer: sends its lock state back as a message.
// Assumes video_up and chan_on change off the rising edge of mclk.
`timescale 1ns/1ps
module remote_deser_model (
    input  wire logic mclk,
    input  wire logic video_up,
    input  wire logic chan_on,
    output logic      lock_msg,
    output logic      lock_valid
);
    initial begin
        lock_msg   = 1'b0;
        lock_valid = 1'b0;
    end
    // Lock pin wired to own interrupt input, sent back
    // Lock follows video link only, never configuration link
    // Sent whatever the forward link does
    // Idle channel toggles data so stale lock is never seen as valid
    always @(posedge mclk) begin
        lock_valid <= chan_on;
        lock_msg   <= chan_on ? video_up : ~lock_msg;
    end
endmodule // remote_deser_model

//--- verification/tb_top.sv
// Self-checking bench for the line-fault and lock status block.
// Assumes the design package is compiled first; blackout shortened to 8.
`timescale 1ns/1ps
module tb_top;
    import fault_lock_pkg::*;
    logic       mclk, resetn, link_en, video_up, chan_on, lmsg, lval;
    logic [1:0] neg, pos;
    logic [7:0] addr, rdata;
    logic       int_out, flag_n, ready, en;
    int         fail_count, tests_run;
    logic [4:0] rows [8] = '{5'h0A, 5'h12, 5'h1C, 5'h16,
                             5'h04, 5'h0C, 5'h10, 5'h15};
    logic [7:0] bad [4] = '{8'h00, 8'h07, 8'h09, 8'hFF};

    remote_deser_model i_remote_deser_model (.mclk(mclk),
        .video_up(video_up), .chan_on(chan_on), .lock_msg(lmsg),
        .lock_valid(lval));
    line_fault_and_lock_report #(.BLACKOUT_CYCLES(8))
        i_line_fault_and_lock_report (.mclk(mclk), .resetn(resetn),
        .clk_en(en), .rev_lock_msg(lmsg), .rev_lock_valid(lval),
        .serial_link_en(link_en), .neg_detect(neg), .pos_detect(pos),
        .reg_addr(addr), .reg_rdata(rdata), .int_out(int_out),
        .line_fault_flag_n(flag_n), .rev_chan_ready(ready));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk1(input logic got, input logic exp, input string m);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                        input string m);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic end_sim;
        $display("tests %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #5000;
        fail_count++;
        end_sim;
    end

    initial begin
        fail_count = 0;
        tests_run  = 0;
        resetn = 1'b0; link_en = 1'b0; video_up = 1'b0; chan_on = 1'b0;
        en = 1'b1;
        neg = 2'h2; pos = 2'h2; addr = CABLE_FAULT_STATUS_ADDR;
        tick(2);
        resetn = 1'b1;
        tick(1);
        chk8(rdata, CABLE_FAULT_STATUS_RST, "status reset");
        chk1(flag_n, 1'b1, "flag reset");
        chk1(ready, 1'b1, "ready reset");
        // Every code of each wire, other wire normal, plus one row with both wires ground
        foreach (rows[i]) begin
            {neg, pos} = rows[i][4:1];
            tick(5);
            chk1(flag_n, rows[i][0], "fault flag");
            chk8(rdata, {4'h0, rows[i][4:1]}, "field");
        end
        $display("fault table done");
        foreach (bad[i]) begin
            addr = bad[i];
            tick(2);
            chk8(rdata, 8'h00, "unmapped read");
        end
        addr = CABLE_FAULT_STATUS_ADDR;
        $display("address decode done");
        // Forward link stays off: lock must still travel back
        chan_on  = 1'b1;
        video_up = 1'b1;
        tick(5);
        chk1(int_out, 1'b1, "lock rise");
        video_up = 1'b0;
        tick(5);
        chk1(int_out, 1'b0, "lock fall");
        video_up = 1'b1;
        tick(5);
        $display("lock loopback done");
        // Lock drop inside blackout is held until channel returns
        link_en = 1'b1;
        tick(1);
        chk1(ready, 1'b0, "blackout start");
        video_up = 1'b0;
        tick(5);
        chk1(ready, 1'b0, "blackout held");
        chk1(int_out, 1'b1, "lock frozen");
        tick(2);
        chk1(ready, 1'b0, "blackout last");
        tick(1);
        chk1(ready, 1'b1, "blackout end");
        chk1(int_out, 1'b1, "lock still held");
        tick(1);
        chk1(int_out, 1'b0, "lock after blackout");
        $display("blackout done");
        // Frozen clock enable: a new fault must not reach the outputs
        en  = 1'b0;
        pos = 2'h1;
        tick(6);
        chk1(flag_n, 1'b1, "flag frozen");
        chk8(rdata, 8'h0A, "status frozen");
        en = 1'b1;
        tick(3);
        chk1(flag_n, 1'b0, "flag after enable");
        chk8(rdata, 8'h09, "status after enable");
        $display("clock enable done");
        // Mid-run reset with a fault still present
        resetn  = 1'b0;
        link_en = 1'b0;
        tick(2);
        chk1(int_out, 1'b0, "int in reset");
        chk1(flag_n, 1'b1, "flag in reset");
        chk1(ready, 1'b1, "ready in reset");
        resetn = 1'b1;
        tick(1);
        chk8(rdata, CABLE_FAULT_STATUS_RST, "status after reset");
        tick(2);
        chk1(flag_n, 1'b0, "flag after reset");
        chk8(rdata, 8'h09, "status live again");
        $display("mid-run reset done");
        end_sim;
    end
endmodule // tb_top
